// ---- usb_init_cfg_pkg.sv ----
package usb_init_cfg_pkg;

    // command codes taken on the parallel port
    localparam logic [7:0] CMD_SET_ADDRESS = 8'hd0;
    localparam logic [7:0] CMD_SET_ENDPOINT_GROUP_ENABLE_BIT = 8'hd8;
    localparam logic [7:0] CMD_SET_MODE = 8'hf3;

    // device_address_enable layout
    localparam int ADDR_MSB = 6;
    localparam int FUNC_EN_BIT = 7;
    localparam logic [6:0] ADDR_RESET = 7'h00;
    localparam logic FUNC_EN_RESET = 1'b0;
    localparam logic FUNC_EN_ON_BUS_RESET = 1'b1;

    // endpoint_group_enable layout
    localparam int EP_GROUP_EN_BIT = 0;
    localparam logic EP_GROUP_EN_RESET = 1'b0;

    // mode_configuration layout
    localparam int NO_SUSPEND_CLK_BIT = 1;
    localparam int CLK_RUNNING_BIT = 2;
    localparam int NAK_ERR_INT_BIT = 3;
    localparam int DATA_PLUS_PULLUP_ENABLE_BIT = 4;
    localparam int EP_MODE_LSB = 6;
    localparam int EP_MODE_MSB = 7;
    localparam logic [7:0] MODE_CFG_RESET = 8'h0e;

    // clock_divider_config layout
    localparam int DIV_MSB = 3;
    localparam int MUST_ONE_BIT = 6;
    localparam int SOF_ONLY_BIT = 7;
    localparam logic [7:0] CLK_DIV_RESET = 8'h0b;
    localparam logic [3:0] DIV_OFF = 4'hf;

    // primary endpoint modes
    localparam logic [1:0] EP_MODE_NON_ISO = 2'h0;
    localparam logic [1:0] EP_MODE_ISO_OUT = 2'h1;
    localparam logic [1:0] EP_MODE_ISO_IN = 2'h2;
    localparam logic [1:0] EP_MODE_ISO_IO = 2'h3;
    localparam logic [7:0] PKT_64 = 8'h40;
    localparam logic [7:0] PKT_128 = 8'h80;
    localparam logic [7:0] PKT_NONE = 8'h00;

    // clock output timing, in reference ticks of the 48 MHz source
    localparam int REF_FREQ_KHZ = 48000;
    localparam int SUSPEND_FREQ_KHZ = 30;
    localparam int SUSPEND_DIV = REF_FREQ_KHZ / SUSPEND_FREQ_KHZ;
    localparam int DIV_CNT_W = 11;
    localparam logic [DIV_CNT_W-1:0] SUSPEND_PERIOD = DIV_CNT_W'(SUSPEND_DIV);
    localparam logic [DIV_CNT_W-1:0] CNT_ZERO = 11'h000;
    localparam logic [DIV_CNT_W-1:0] CNT_ONE = 11'h001;

    // command sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_EP,
        ST_MODE1,
        ST_MODE2,
        ST_IGNORE
    } cmd_state_type;

endpackage

// ---- cmd_sequencer.sv ----
`timescale 1ns/100ps
module cmd_sequencer (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // parallel port
    input wire logic i_cmd_wr,
    input wire logic i_data_wr,
    input wire logic [7:0] i_data,
    // register write strobes
    output logic o_wr_addr,
    output logic o_wr_ep,
    output logic o_wr_mode,
    output logic o_wr_div,
    output logic [7:0] o_wr_byte
);

    usb_init_cfg_pkg::cmd_state_type state_q, state_d;

    // command write restarts the sequence; data bytes walk it in order
    always_comb begin
        state_d = state_q;
        if (i_cmd_wr) begin
            case (i_data)
                usb_init_cfg_pkg::CMD_SET_ADDRESS: state_d = usb_init_cfg_pkg::ST_ADDR;
                usb_init_cfg_pkg::CMD_SET_ENDPOINT_GROUP_ENABLE_BIT: state_d = usb_init_cfg_pkg::ST_EP;
                usb_init_cfg_pkg::CMD_SET_MODE: state_d = usb_init_cfg_pkg::ST_MODE1;
                default: state_d = usb_init_cfg_pkg::ST_IGNORE;
            endcase
        end else if (i_data_wr) begin
            case (state_q)
                usb_init_cfg_pkg::ST_MODE1: state_d = usb_init_cfg_pkg::ST_MODE2;
                default: state_d = usb_init_cfg_pkg::ST_IGNORE;
            endcase
        end
    end

    // strobes only for data bytes that follow their own command
    always_comb begin
        o_wr_addr = 1'b0;
        o_wr_ep = 1'b0;
        o_wr_mode = 1'b0;
        o_wr_div = 1'b0;
        if (i_data_wr && !i_cmd_wr) begin
            case (state_q)
                usb_init_cfg_pkg::ST_ADDR: o_wr_addr = 1'b1;
                usb_init_cfg_pkg::ST_EP: o_wr_ep = 1'b1;
                usb_init_cfg_pkg::ST_MODE1: o_wr_mode = 1'b1;
                usb_init_cfg_pkg::ST_MODE2: o_wr_div = 1'b1;
                default: o_wr_addr = 1'b0;
            endcase
        end
    end

    assign o_wr_byte = i_data;

    // state registers, frozen while clock enable is low
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            state_q <= usb_init_cfg_pkg::ST_IDLE;
        end else if (i_ce) begin
            state_q <= state_d;
        end
    end

endmodule

// ---- clock_out_divider.sv ----
`timescale 1ns/100ps
module clock_out_divider (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // reference tick at the 48 MHz rate
    input wire logic i_ref_tick,
    // control
    input wire logic [3:0] i_factor,
    input wire logic i_slow,
    // pin
    output logic o_clock_output_pin,
    output logic o_off
);

    logic [usb_init_cfg_pkg::DIV_CNT_W-1:0] cnt_q, cnt_d, period;
    logic pin_q, pin_d;

    assign o_off = (i_factor == usb_init_cfg_pkg::DIV_OFF);
    // odd periods give a slightly uneven duty cycle, which is acceptable here
    assign period = i_slow ? usb_init_cfg_pkg::SUSPEND_PERIOD
        : (usb_init_cfg_pkg::DIV_CNT_W'(i_factor) + usb_init_cfg_pkg::CNT_ONE);

    // count reference ticks over one output period
    always_comb begin
        cnt_d = cnt_q;
        pin_d = pin_q;
        if (o_off) begin
            cnt_d = usb_init_cfg_pkg::CNT_ZERO;
            pin_d = 1'b0;
        end else if (i_ref_tick) begin
            if (cnt_q + usb_init_cfg_pkg::CNT_ONE >= period) begin
                cnt_d = usb_init_cfg_pkg::CNT_ZERO;
            end else begin
                cnt_d = cnt_q + usb_init_cfg_pkg::CNT_ONE;
            end
            pin_d = (cnt_d < (period >> 1));
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            cnt_q <= usb_init_cfg_pkg::CNT_ZERO;
            pin_q <= 1'b0;
        end else if (i_ce) begin
            cnt_q <= cnt_d;
            pin_q <= pin_d;
        end
    end

    assign o_clock_output_pin = pin_q;

endmodule

// ---- usb_device_init_config_regs.sv ----
`timescale 1ns/100ps
// What this block does
// - set-address loads 7-bit address; bus reset clears it to zero
// - address byte bit 7 is function enable; bus reset sets it
// - endpoint-enable bit 0 enables endpoints one and two; endpoint zero always on
// - endpoints one and two enabled only while function enable is set
// - mode bit 1 low gives 30 kHz clock output during suspend
// - mode bit 2 low stops internal clocks during suspend
// - mode bit 3 enables interrupts on NAK and error transactions
// - mode bit 4 enables D+ pull-up while VBUS is present
// - bus reset keeps mode and divider bytes; only device reset restores them
// - mode bits 7-6 select primary endpoint configuration
// - divide factor sets output to 48 MHz over factor plus one
// - divide factor all ones turns the clock output off
// - divider bit 7 makes interrupt pin fire on SOF only
// - interrupt pin mode adds SOF to interrupts; SOF-only overrides it
// - primary endpoint mode sets maximum packet sizes
module usb_device_init_config_regs (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,

    // parallel host port
    input wire logic i_cmd_wr,
    input wire logic i_data_wr,
    input wire logic [7:0] i_data,

    // usb engine status
    input wire logic i_bus_reset,
    input wire logic i_suspend,
    input wire logic i_vbus,
    input wire logic i_sof_rx,
    input wire logic i_nak_err_event,
    input wire logic i_int_reg_pending,
    input wire logic i_int_pin_mode,
    input wire logic i_ref_tick,

    // address and endpoints
    output logic [6:0] o_device_address,
    output logic o_function_enable,
    output logic o_control_endpoint_enable,
    output logic o_endpoint_group_enable,

    // mode
    output logic o_internal_clk_run,
    output logic o_nak_err_int_enable,
    output logic o_nak_err_int,
    output logic o_data_plus_pullup_enable,
    output logic [1:0] o_primary_endpoint_mode,
    output logic [7:0] o_primary_out_max_pkt,
    output logic [7:0] o_primary_in_max_pkt,

    // clock output and interrupt pin
    output logic o_clock_output_pin,
    output logic o_clock_output_off,
    output logic o_sof_only_mode,
    output logic o_int
);

    // strobes and byte from the command sequencer
    logic wr_addr;
    logic wr_ep;
    logic wr_mode;
    logic wr_div;
    logic [7:0] wr_byte;

    // the four host-written registers
    logic [6:0] addr_q;
    logic [6:0] addr_d;
    logic func_en_q;
    logic func_en_d;
    logic ep_en_q;
    logic ep_en_d;
    logic [7:0] mode_q;
    logic [7:0] mode_d;
    logic [7:0] div_q;
    logic [7:0] div_d;

    // named fields of the stored bytes
    logic no_suspend_clk;
    logic keep_clk_run;
    logic nak_int_mode;
    logic pullup_mode;
    logic [1:0] ep_mode;
    logic [3:0] div_factor;
    logic sof_only;

    // registered status outputs and the slow clock select
    logic run_q;
    logic run_d;
    logic pull_q;
    logic pull_d;
    logic nak_int_q;
    logic nak_int_d;
    logic [7:0] pkt_out_q;
    logic [7:0] pkt_out_d;
    logic [7:0] pkt_in_q;
    logic [7:0] pkt_in_d;
    logic int_q;
    logic int_d;
    logic slow_clk;

    // command decode and byte sequencing
    cmd_sequencer u_seq (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_cmd_wr(i_cmd_wr),
        .i_data_wr(i_data_wr),
        .i_data(i_data),
        .o_wr_addr(wr_addr),
        .o_wr_ep(wr_ep),
        .o_wr_mode(wr_mode),
        .o_wr_div(wr_div),
        .o_wr_byte(wr_byte)
    );

    // address and enable; bus reset wins over a host write in the same cycle
    always_comb begin
        addr_d = addr_q;
        func_en_d = func_en_q;
        ep_en_d = ep_en_q;
        if (i_bus_reset) begin
            addr_d = usb_init_cfg_pkg::ADDR_RESET;
            func_en_d = usb_init_cfg_pkg::FUNC_EN_ON_BUS_RESET;
        end else if (wr_addr) begin
            addr_d = wr_byte[usb_init_cfg_pkg::ADDR_MSB:0];
            func_en_d = wr_byte[usb_init_cfg_pkg::FUNC_EN_BIT];
        end
        // reserved bits of this byte are simply not stored
        if (wr_ep) begin
            ep_en_d = wr_byte[usb_init_cfg_pkg::EP_GROUP_EN_BIT];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            addr_q <= usb_init_cfg_pkg::ADDR_RESET;
            func_en_q <= usb_init_cfg_pkg::FUNC_EN_RESET;
            ep_en_q <= usb_init_cfg_pkg::EP_GROUP_EN_RESET;
        end else if (i_ce) begin
            addr_q <= addr_d;
            func_en_q <= func_en_d;
            ep_en_q <= ep_en_d;
        end
    end

    // mode bytes ignore bus reset entirely
    always_comb begin
        mode_d = mode_q;
        div_d = div_q;
        if (wr_mode) begin
            mode_d = wr_byte;
        end
        if (wr_div) begin
            div_d = wr_byte;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            mode_q <= usb_init_cfg_pkg::MODE_CFG_RESET;
            div_q <= usb_init_cfg_pkg::CLK_DIV_RESET;
        end else if (i_ce) begin
            mode_q <= mode_d;
            div_q <= div_d;
        end
    end

    // field decode, so the logic below reads names rather than bit positions
    assign no_suspend_clk = mode_q[usb_init_cfg_pkg::NO_SUSPEND_CLK_BIT];
    assign keep_clk_run = mode_q[usb_init_cfg_pkg::CLK_RUNNING_BIT];
    assign nak_int_mode = mode_q[usb_init_cfg_pkg::NAK_ERR_INT_BIT];
    assign pullup_mode = mode_q[usb_init_cfg_pkg::DATA_PLUS_PULLUP_ENABLE_BIT];
    assign ep_mode = mode_q[usb_init_cfg_pkg::EP_MODE_MSB:usb_init_cfg_pkg::EP_MODE_LSB];
    assign div_factor = div_q[usb_init_cfg_pkg::DIV_MSB:0];
    assign sof_only = div_q[usb_init_cfg_pkg::SOF_ONLY_BIT];

    // internal clocks run unless suspended with the run bit clear
    always_comb begin
        run_d = keep_clk_run || !i_suspend;
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            run_q <= 1'b1;
        end else if (i_ce) begin
            run_q <= run_d;
        end
    end

    // pull-up follows vbus, so a detached device never drives the line
    always_comb begin
        pull_d = pullup_mode && i_vbus;
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            pull_q <= 1'b0;
        end else if (i_ce) begin
            pull_q <= pull_d;
        end
    end

    // nak and error events pass only while the interrupt mode allows them
    always_comb begin
        nak_int_d = nak_int_mode && i_nak_err_event;
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            nak_int_q <= 1'b0;
        end else if (i_ce) begin
            nak_int_q <= nak_int_d;
        end
    end

    // primary endpoint packet sizes; zero marks a direction the mode leaves unused
    always_comb begin
        pkt_out_d = usb_init_cfg_pkg::PKT_64;
        pkt_in_d = usb_init_cfg_pkg::PKT_64;
        case (ep_mode)
            usb_init_cfg_pkg::EP_MODE_NON_ISO: begin
                pkt_out_d = usb_init_cfg_pkg::PKT_64;
                pkt_in_d = usb_init_cfg_pkg::PKT_64;
            end
            usb_init_cfg_pkg::EP_MODE_ISO_OUT: begin
                pkt_out_d = usb_init_cfg_pkg::PKT_128;
                pkt_in_d = usb_init_cfg_pkg::PKT_NONE;
            end
            usb_init_cfg_pkg::EP_MODE_ISO_IN: begin
                pkt_out_d = usb_init_cfg_pkg::PKT_NONE;
                pkt_in_d = usb_init_cfg_pkg::PKT_128;
            end
            usb_init_cfg_pkg::EP_MODE_ISO_IO: begin
                pkt_out_d = usb_init_cfg_pkg::PKT_64;
                pkt_in_d = usb_init_cfg_pkg::PKT_64;
            end
            default: begin
                pkt_out_d = usb_init_cfg_pkg::PKT_64;
                pkt_in_d = usb_init_cfg_pkg::PKT_64;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            pkt_out_q <= usb_init_cfg_pkg::PKT_64;
            pkt_in_q <= usb_init_cfg_pkg::PKT_64;
        end else if (i_ce) begin
            pkt_out_q <= pkt_out_d;
            pkt_in_q <= pkt_in_d;
        end
    end

    // interrupt pin; sof-only overrides the pin mode from the dma register
    always_comb begin
        if (sof_only) begin
            int_d = i_sof_rx;
        end else begin
            int_d = i_int_reg_pending || (i_int_pin_mode && i_sof_rx);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            int_q <= 1'b0;
        end else if (i_ce) begin
            int_q <= int_d;
        end
    end

    // slow clock only while suspended and not told to keep the rate
    assign slow_clk = i_suspend && !no_suspend_clk;

    clock_out_divider u_div (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_ref_tick(i_ref_tick),
        .i_factor(div_factor),
        .i_slow(slow_clk),
        .o_clock_output_pin(o_clock_output_pin),
        .o_off(o_clock_output_off)
    );

    // address and endpoint outputs
    assign o_device_address = addr_q;
    assign o_function_enable = func_en_q;
    assign o_control_endpoint_enable = 1'b1;
    assign o_endpoint_group_enable = ep_en_q && func_en_q;

    // mode outputs
    assign o_internal_clk_run = run_q;
    assign o_nak_err_int_enable = nak_int_mode;
    assign o_nak_err_int = nak_int_q;
    assign o_data_plus_pullup_enable = pull_q;
    assign o_primary_endpoint_mode = ep_mode;
    assign o_primary_out_max_pkt = pkt_out_q;
    assign o_primary_in_max_pkt = pkt_in_q;

    // interrupt outputs
    assign o_sof_only_mode = sof_only;
    assign o_int = int_q;

endmodule

// ---- usb_device_init_config_regs_props.sv ----
`timescale 1ns/100ps
module usb_device_init_config_regs_props (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // watched inputs
    input wire logic i_cmd_wr,
    input wire logic i_data_wr,
    input wire logic [7:0] i_data,
    input wire logic i_bus_reset,
    input wire logic i_vbus,
    input wire logic i_sof_rx,
    input wire logic i_nak_err_event,
    input wire logic i_int_reg_pending,
    input wire logic i_int_pin_mode,
    // watched outputs
    input wire logic [6:0] o_device_address,
    input wire logic o_function_enable,
    input wire logic o_nak_err_int_enable,
    input wire logic o_nak_err_int,
    input wire logic o_data_plus_pullup_enable,
    input wire logic [1:0] o_primary_endpoint_mode,
    input wire logic [7:0] o_primary_out_max_pkt,
    input wire logic [7:0] o_primary_in_max_pkt,
    input wire logic o_clock_output_pin,
    input wire logic o_clock_output_off,
    input wire logic o_sof_only_mode,
    input wire logic o_int
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // past() guards skip the first edge after reset, when inputs were ignored
    chk_addr_load: assert property (
        i_cmd_wr && i_data == 8'hd0 ##1 i_data_wr && !i_cmd_wr && !i_bus_reset
        |=> {o_function_enable, o_device_address} == $past(i_data)) else $error("address load");
    chk_bus_reset: assert property (
        i_bus_reset |=> o_device_address == 7'h00 && o_function_enable) else $error("bus reset");
    chk_bus_keep: assert property (
        i_bus_reset && !i_cmd_wr && !i_data_wr |=> $stable(o_primary_endpoint_mode)
        && $stable(o_sof_only_mode) && $stable(o_nak_err_int_enable)) else $error("mode lost");
    chk_nak_gate: assert property (
        $past(i_nrst) |-> o_nak_err_int == ($past(i_nak_err_event) && $past(o_nak_err_int_enable)))
        else $error("nak interrupt");
    chk_pullup_vbus: assert property (
        $past(i_nrst) && !$past(i_vbus) |-> !o_data_plus_pullup_enable) else $error("pullup");
    chk_int_sof: assert property (
        $past(i_nrst) && $past(o_sof_only_mode) |-> o_int == $past(i_sof_rx)) else $error("sof int");
    chk_int_normal: assert property (
        $past(i_nrst) && !$past(o_sof_only_mode) |-> o_int == ($past(i_int_reg_pending)
        || $past(i_int_pin_mode) && $past(i_sof_rx))) else $error("normal int");
    chk_pkt_size: assert property (
        $past(i_nrst) |-> {o_primary_out_max_pkt, o_primary_in_max_pkt} ==
        ($past(o_primary_endpoint_mode) == 2'h1 ? 16'h8000 :
        $past(o_primary_endpoint_mode) == 2'h2 ? 16'h0080 : 16'h4040)) else $error("pkt size");
    chk_clk_off: assert property (
        o_clock_output_off [*2] |-> !o_clock_output_pin) else $error("clock pin not off");
    // main scenarios
    cover property (i_bus_reset);
    cover property (o_sof_only_mode && o_int);
    cover property (o_clock_output_off);
endmodule
bind usb_device_init_config_regs usb_device_init_config_regs_props u_props (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_cmd_wr(i_cmd_wr), .i_data_wr(i_data_wr), .i_data(i_data),
    .i_bus_reset(i_bus_reset), .i_vbus(i_vbus), .i_sof_rx(i_sof_rx),
    .i_nak_err_event(i_nak_err_event), .i_int_reg_pending(i_int_reg_pending),
    .i_int_pin_mode(i_int_pin_mode), .o_device_address(o_device_address),
    .o_function_enable(o_function_enable), .o_nak_err_int_enable(o_nak_err_int_enable),
    .o_nak_err_int(o_nak_err_int), .o_data_plus_pullup_enable(o_data_plus_pullup_enable),
    .o_primary_endpoint_mode(o_primary_endpoint_mode),
    .o_primary_out_max_pkt(o_primary_out_max_pkt), .o_primary_in_max_pkt(o_primary_in_max_pkt),
    .o_clock_output_pin(o_clock_output_pin), .o_clock_output_off(o_clock_output_off),
    .o_sof_only_mode(o_sof_only_mode), .o_int(o_int));

// ---- host_port_model.sv ----
`timescale 1ns/100ps
module host_port_model (
    // clock
    input wire logic i_clk,
    // parallel port toward the device
    output logic o_cmd_wr = 1'b0,
    output logic o_data_wr = 1'b0,
    output logic [7:0] o_data = 8'h00
);
    // command strobe first, then each data byte on the following edges
    task automatic send(input logic [7:0] code, input logic [7:0] b[$]);
        @(posedge i_clk);
        o_cmd_wr <= 1'b1;
        o_data <= code;
        foreach (b[i]) begin
            @(posedge i_clk);
            o_cmd_wr <= 1'b0;
            o_data_wr <= 1'b1;
            o_data <= b[i];
        end
        @(posedge i_clk);
        o_data_wr <= 1'b0;
        o_cmd_wr <= 1'b0;
        // idle bus shows the inverse, so a stale byte is never reused
        o_data <= ~o_data;
    endtask
endmodule

// ---- usb_device_init_config_regs_tb.sv ----
`timescale 1ns/100ps
module usb_device_init_config_regs_tb;
    logic i_clk = 1'b0, i_nrst = 1'b0, i_bus_reset = 1'b0, i_suspend = 1'b0, i_vbus = 1'b1;
    logic i_sof_rx = 1'b0, i_nak_err_event = 1'b0, i_int_reg_pending = 1'b0, i_int_pin_mode = 1'b0;
    logic i_ref_tick = 1'b1, cmd_wr, data_wr, pin, prev_pin = 1'b0, fe, ep, ctl, run, nak_en;
    logic nak_int, pu, sof_only, off, irq;
    logic [7:0] data, pkt_out, pkt_in, ea, ee, em, ed;
    logic [6:0] addr;
    logic [1:0] mode;
    int error_cnt = 0, checked = 0, cnt = 0, gap = 0;
    initial begin
        forever #12.5 i_clk = ~i_clk;
    end
    host_port_model u_host (.i_clk(i_clk), .o_cmd_wr(cmd_wr), .o_data_wr(data_wr), .o_data(data));
    usb_device_init_config_regs u_dut (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'b1), .i_cmd_wr(cmd_wr), .i_data_wr(data_wr),
        .i_data(data), .i_bus_reset(i_bus_reset), .i_suspend(i_suspend), .i_vbus(i_vbus),
        .i_sof_rx(i_sof_rx), .i_nak_err_event(i_nak_err_event), .i_ref_tick(i_ref_tick),
        .i_int_reg_pending(i_int_reg_pending), .i_int_pin_mode(i_int_pin_mode),
        .o_device_address(addr), .o_function_enable(fe), .o_control_endpoint_enable(ctl),
        .o_endpoint_group_enable(ep), .o_internal_clk_run(run), .o_nak_err_int_enable(nak_en),
        .o_nak_err_int(nak_int), .o_data_plus_pullup_enable(pu), .o_primary_endpoint_mode(mode),
        .o_primary_out_max_pkt(pkt_out), .o_primary_in_max_pkt(pkt_in), .o_clock_output_pin(pin),
        .o_clock_output_off(off), .o_sof_only_mode(sof_only), .o_int(irq));
    // clock pin period in core cycles; one reference tick per cycle
    always @(posedge i_clk) begin
        prev_pin <= pin;
        cnt <= (pin && !prev_pin) ? 1 : cnt + 1;
        if (pin && !prev_pin) begin
            gap <= cnt;
        end
    end
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    function automatic logic [15:0] pkt(input logic [1:0] m);
        return m == 2'h1 ? 16'h8000 : m == 2'h2 ? 16'h0080 : 16'h4040;
    endfunction
    // expected outputs from the bench copy of the four registers
    task automatic check_all;
        logic [15:0] e;
        e = {6'h0, ea[6:0], ea[7], ee[0] & ea[7], 1'b1};
        cmp({6'h0, addr, fe, ep, ctl}, e);
        e = {11'h0, em[2] | !i_suspend, em[3], em[4] & i_vbus, ed[7], ed[3:0] == 4'hf};
        cmp({11'h0, run, nak_en, pu, sof_only, off}, e);
        cmp({pkt_out, pkt_in}, pkt(em[7:6]));
        cmp({14'h0, mode}, {14'h0, em[7:6]});
    endtask
    task automatic sof_pulse(input logic exp);
        @(posedge i_clk) i_sof_rx <= 1'b1;
        @(posedge i_clk) i_sof_rx <= 1'b0;
        #1;
        cmp({15'h0, irq}, {15'h0, exp});
    endtask
    task automatic summarize;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'h98b49273));
        {ea, ee, em, ed} = 32'h00000e0b;
        repeat (5) @(posedge i_clk);
        i_nrst <= 1'b1;
        tick(2);
        check_all();
        // first pass: address 7f with function off, so the group must stay off
        for (int i = 0; i < 8; i++) begin
            ea = (i == 0) ? 8'h7f : 8'($urandom);
            ee = {7'h0, (i == 0) | 1'($urandom)};
            u_host.send(8'hd0, '{ea});
            u_host.send(8'hd8, '{ee});
            tick(2);
            check_all();
        end
        @(posedge i_clk) i_bus_reset <= 1'b1;
        @(posedge i_clk) i_bus_reset <= 1'b0;
        ea = 8'h80;
        tick(2);
        check_all();
        // every primary endpoint mode; factors 1, 4, 8, 12; a third byte to ignore
        for (int m = 0; m < 4; m++) begin
            em = {m[1:0], 1'b0, 4'($urandom), 1'b0};
            ed = {4'h4, 4'(m * 11 / 3 + 1)};
            u_host.send(8'hf3, '{em, ed, 8'hc1});
            u_host.send(8'hf4, '{8'h55});
            @(posedge i_clk) i_nak_err_event <= 1'b1;
            @(posedge i_clk) i_nak_err_event <= 1'b0;
            i_vbus <= 1'($urandom);
            #1 cmp({15'h0, nak_int}, {15'h0, em[3]});
            tick(3 * int'(ed[3:0]) + 8);
            check_all();
            cmp(16'(gap), 16'(ed[3:0]) + 16'h1);
        end
        {em, ed} = 16'h004b;
        u_host.send(8'hf3, '{em, ed});
        @(posedge i_clk) i_suspend <= 1'b1;
        tick(3300);
        cmp(16'(gap), 16'h0640);
        check_all();
        @(posedge i_clk) i_suspend <= 1'b0;
        {em, ed} = 16'h0e4f;
        u_host.send(8'hf3, '{em, ed});
        tick(20);
        check_all();
        cmp({15'h0, pin}, 16'h0);
        ed = 8'hcb;
        u_host.send(8'hf3, '{em, ed});
        @(posedge i_clk) i_int_reg_pending <= 1'b1;
        tick(3);
        cmp({15'h0, irq}, 16'h0);
        sof_pulse(1'b1);
        ed = 8'h4b;
        u_host.send(8'hf3, '{em, ed});
        tick(2);
        cmp({15'h0, irq}, 16'h1);
        @(posedge i_clk) i_int_reg_pending <= 1'b0;
        sof_pulse(1'b0);
        @(posedge i_clk) i_int_pin_mode <= 1'b1;
        sof_pulse(1'b1);
        // a device reset mid-run brings back every default
        @(posedge i_clk) i_nrst <= 1'b0;
        tick(3);
        @(posedge i_clk) i_nrst <= 1'b1;
        {ea, ee, em, ed} = 32'h00000e0b;
        tick(2);
        check_all();
        summarize();
    end
    // run needs about 3600 cycles
    initial begin
        repeat (20000) @(posedge i_clk);
        error_cnt++;
        summarize();
    end
endmodule
